// >>> core/lhbi_pkg.sv
package lhbi_pkg;

  // ****************************************
  // host port geometry
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_IDX_LSB = 1;
  localparam int MEM_IDX_W = 4;

  // ****************************************
  // strap decode
  // ****************************************
  localparam int STRAP_W = 5;
  localparam int STRAP_ENDIAN_BIT = 3;
  localparam int STRAP_PWRPOL_BIT = 4;
  localparam logic [2:0] MODE_PER_BYTE = 3'h7;
  localparam logic BS_PER_BYTE = 1'h0;

  // ****************************************
  // register map
  // ****************************************
  localparam int AV_AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_RFSH_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_BS_BIT = 5;
  localparam int ST_MODE_BIT = 6;
  localparam int ST_PEND_BIT = 7;
  localparam int ST_CNT_LSB = 8;

  // ****************************************
  // carriers and states
  // ****************************************
  typedef struct packed {
    logic we;
    logic [1:0] be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lhbi_req_s;

  typedef struct packed {
    logic [STRAP_W-1:0] cfg;
    logic bs_n;
  } lhbi_strap_s;

  typedef enum logic [2:0] {
    L_IDLE = 3'b001,
    L_WAIT = 3'b010,
    L_DONE = 3'b100
  } lhbi_lstate_e;

endpackage

// >>> core/lhbi_top.sv
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module lhbi_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_bus_clk_i,
  input wire logic [4:0] strap_cfg_i,
  input wire logic bus_status_strap_n_i,
  input wire logic device_sel_n_i,
  input wire logic [15:0] host_addr_in_i,
  input wire logic [15:0] host_data_io_i,
  output logic [15:0] host_data_io_o,
  output logic host_data_io_oe_o,
  input wire logic low_byte_wr_n_i,
  input wire logic high_byte_wr_n_i,
  input wire logic low_byte_rd_n_i,
  input wire logic high_byte_rd_n_i,
  output logic hold_n_o,
  output logic panel_power_ctl_o,
  input wire logic refresh_req_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  // ****************************************
  // strap capture
  // ****************************************
  logic [5:0] strap_s1;
  logic [5:0] strap_s2;
  logic [5:0] strap_s3;
  lhbi_pkg::lhbi_strap_s strap_stable;
  lhbi_pkg::lhbi_strap_s strap_q;
  logic mode_pb;
  logic big_end;
  logic pwr_pol;

  always_ff @(posedge clk_i) begin
    strap_s1 <= {strap_cfg_i, bus_status_strap_n_i};
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  always_ff @(posedge clk_i) begin
    if (strap_s2 == strap_s3) begin
      strap_stable <= strap_s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= strap_stable;
    end
  end

  always_comb begin
    mode_pb = (strap_q.cfg[2:0] == lhbi_pkg::MODE_PER_BYTE) &&
              (strap_q.bs_n == lhbi_pkg::BS_PER_BYTE);
    big_end = strap_q.cfg[lhbi_pkg::STRAP_ENDIAN_BIT];
    pwr_pol = strap_q.cfg[lhbi_pkg::STRAP_PWRPOL_BIT];
  end

  // ****************************************
  // register slave
  // ****************************************
  logic [1:0] ctrl;
  logic [7:0] acc_cnt;
  logic pending;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[lhbi_pkg::ST_STRAP_LSB +: lhbi_pkg::STRAP_W] = strap_q.cfg;
    status_word[lhbi_pkg::ST_BS_BIT] = strap_q.bs_n;
    status_word[lhbi_pkg::ST_MODE_BIT] = mode_pb;
    status_word[lhbi_pkg::ST_PEND_BIT] = pending;
    status_word[lhbi_pkg::ST_CNT_LSB +: 8] = acc_cnt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      if (avs_address_i == lhbi_pkg::REG_CTRL) begin
        avs_readdata_o <= {30'h0, ctrl};
      end else if (avs_address_i == lhbi_pkg::REG_STATUS) begin
        avs_readdata_o <= status_word;
      end else begin
        avs_readdata_o <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= lhbi_pkg::CTRL_RESET;
    end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
                 avs_address_i == lhbi_pkg::REG_CTRL) begin
      ctrl <= avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      panel_power_ctl_o <= 1'b0;
    end else begin
      panel_power_ctl_o <= ctrl[lhbi_pkg::CTRL_PWR_BIT] ~^ pwr_pol;
    end
  end

  // ****************************************
  // core side of the crossing
  // ****************************************
  logic req_tgl;
  logic ack_tgl;
  logic rq_s1;
  logic rq_s2;
  logic rq_s3;
  logic rq_f;
  logic rq_done;
  logic busy;
  logic serve;
  lhbi_pkg::lhbi_req_s link_req;
  lhbi_pkg::lhbi_req_s req_sw;
  logic [lhbi_pkg::MEM_IDX_W-1:0] idx;
  logic [15:0] rd_raw;
  logic [15:0] rd_sw;

  always_ff @(posedge clk_i) begin
    rq_s1 <= req_tgl;
    rq_s2 <= rq_s1;
    rq_s3 <= rq_s2;
    rq_f <= (rq_s2 & rq_s3) | (rq_f & (rq_s2 | rq_s3));
  end

  always_comb begin
    pending = rq_f ^ rq_done;
    busy = refresh_req_i | ctrl[lhbi_pkg::CTRL_RFSH_BIT];
    serve = pending & ~busy;
    idx = link_req.addr[lhbi_pkg::MEM_IDX_LSB +: lhbi_pkg::MEM_IDX_W];
    req_sw = link_req;
    if (big_end) begin
      req_sw.be = {link_req.be[0], link_req.be[1]};
      req_sw.wdata = {link_req.wdata[7:0], link_req.wdata[15:8]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rq_done <= 1'b0;
      ack_tgl <= 1'b0;
      acc_cnt <= '0;
    end else if (serve) begin
      rq_done <= rq_f;
      ack_tgl <= ~ack_tgl;
      acc_cnt <= acc_cnt + 8'h01;
    end
  end

  for (genvar b = 0; b < 2; b++) begin : g_lane
    logic [7:0] lane_mem [lhbi_pkg::MEM_DEPTH];
    logic [7:0] rd_byte;
    always_ff @(posedge clk_i) begin
      if (serve && req_sw.we && req_sw.be[b]) begin
        lane_mem[idx] <= req_sw.wdata[8*b +: 8];
      end
      if (serve && !req_sw.we) begin
        rd_byte <= lane_mem[idx];
      end
    end
  end

  always_comb begin
    rd_raw = {g_lane[1].rd_byte, g_lane[0].rd_byte};
    rd_sw = big_end ? {rd_raw[7:0], rd_raw[15:8]} : rd_raw;
  end

  // ****************************************
  // link side on the bus clock
  // ****************************************
  logic [2:0] lx_s1;
  logic [2:0] lx_s2;
  logic [2:0] lx_s3;
  logic [2:0] lx_f;
  logic lrst;
  logic mode_l;
  logic ack_f;
  logic ack_seen;
  logic wr_any;
  logic rd_any;
  logic start;
  logic ack_evt;
  lhbi_pkg::lhbi_lstate_e l_state;

  always_ff @(posedge host_bus_clk_i) begin
    lx_s1 <= {ack_tgl, mode_pb, rst_i};
    lx_s2 <= lx_s1;
    lx_s3 <= lx_s2;
    lx_f <= (lx_s2 & lx_s3) | (lx_f & (lx_s2 | lx_s3));
  end

  always_comb begin
    lrst = lx_f[0];
    mode_l = lx_f[1];
    ack_f = lx_f[2];
    wr_any = ~low_byte_wr_n_i | ~high_byte_wr_n_i;
    rd_any = ~low_byte_rd_n_i | ~high_byte_rd_n_i;
    start = (l_state == lhbi_pkg::L_IDLE) && mode_l && !device_sel_n_i &&
            (wr_any || rd_any);
    ack_evt = ack_f ^ ack_seen;
  end

  always_ff @(posedge host_bus_clk_i) begin
    if (lrst) begin
      l_state <= lhbi_pkg::L_IDLE;
      hold_n_o <= 1'b1;
      host_data_io_oe_o <= 1'b0;
      host_data_io_o <= '0;
      req_tgl <= 1'b0;
      ack_seen <= 1'b0;
      link_req <= '0;
    end else begin
      case (l_state)
        lhbi_pkg::L_IDLE: begin
          hold_n_o <= 1'b1;
          host_data_io_oe_o <= 1'b0;
          if (start) begin
            link_req.we <= wr_any;
            link_req.be <= wr_any ? {~high_byte_wr_n_i, ~low_byte_wr_n_i} :
                                    {~high_byte_rd_n_i, ~low_byte_rd_n_i};
            link_req.addr <= host_addr_in_i;
            link_req.wdata <= host_data_io_i;
            req_tgl <= ~req_tgl;
            hold_n_o <= 1'b0;
            l_state <= lhbi_pkg::L_WAIT;
          end
        end
        lhbi_pkg::L_WAIT: begin
          hold_n_o <= device_sel_n_i | ack_evt;
          if (ack_evt) begin
            ack_seen <= ack_f;
            l_state <= lhbi_pkg::L_DONE;
            if (!link_req.we) begin
              host_data_io_o <= rd_sw;
              host_data_io_oe_o <= !device_sel_n_i && rd_any;
            end
          end
        end
        lhbi_pkg::L_DONE: begin
          hold_n_o <= 1'b1;
          if (device_sel_n_i || !(wr_any || rd_any)) begin
            host_data_io_oe_o <= 1'b0;
            l_state <= lhbi_pkg::L_IDLE;
          end
        end
        default: begin
          l_state <= lhbi_pkg::L_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_read_done;
    (l_state == lhbi_pkg::L_WAIT) && ack_evt && !link_req.we && !device_sel_n_i && rd_any;
  endsequence

  sequence s_waiting;
    (l_state == lhbi_pkg::L_WAIT) && !ack_evt && !device_sel_n_i;
  endsequence

  a_read_drive: assert property (@(posedge host_bus_clk_i) disable iff (rst_i || lrst)
    s_read_done |=> host_data_io_oe_o && hold_n_o && host_data_io_o == $past(rd_sw))
    else $error("read data not driven after ack");

  a_hold_start: assert property (@(posedge host_bus_clk_i) disable iff (rst_i || lrst)
    start |=> !hold_n_o && l_state == lhbi_pkg::L_WAIT)
    else $error("hold not asserted on access start");

  a_hold_wait: assert property (@(posedge host_bus_clk_i) disable iff (rst_i || lrst)
    s_waiting |=> !hold_n_o)
    else $error("hold released before grant");

  a_hold_release: assert property (@(posedge host_bus_clk_i) disable iff (rst_i || lrst)
    ((l_state == lhbi_pkg::L_WAIT) && ack_evt) |=> hold_n_o ##1 hold_n_o)
    else $error("hold not released after grant");

  a_hold_desel: assert property (@(posedge host_bus_clk_i) disable iff (rst_i || lrst)
    device_sel_n_i |=> hold_n_o && !host_data_io_oe_o || l_state == lhbi_pkg::L_DONE)
    else $error("hold active while deselected");

  a_other_mode: assert property (@(posedge host_bus_clk_i) disable iff (rst_i || lrst)
    (l_state == lhbi_pkg::L_IDLE && !mode_l) |=> l_state == lhbi_pkg::L_IDLE)
    else $error("response outside selected mode");

  a_rfsh_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (pending && busy) |=> ack_tgl == $past(ack_tgl))
    else $error("host served during refresh");

  a_serve_now: assert property (@(posedge clk_i) disable iff (rst_i)
    (pending && !busy) |=> ack_tgl != $past(ack_tgl) && acc_cnt == $past(acc_cnt) + 8'h01)
    else $error("granted access not served");

  a_strap_take: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> strap_q == $past(strap_stable))
    else $error("straps not captured at release");

  a_strap_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> $stable(strap_q))
    else $error("straps changed outside reset");

  a_panel_pol: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> panel_power_ctl_o == ($past(ctrl[0]) ~^ $past(pwr_pol)))
    else $error("panel power polarity wrong");

endmodule
`default_nettype wire

// >>> verif/lhbi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lhbi_host_model (
  input wire logic bus_clk_i,
  input wire logic hold_n_i,
  input wire logic [15:0] data_i,
  output logic sel_n_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o,
  output logic wr_lo_n_o,
  output logic wr_hi_n_o,
  output logic rd_lo_n_o,
  output logic rd_hi_n_o,
  output wire logic ack_n_o
);
  initial begin
    {sel_n_o, wr_lo_n_o, wr_hi_n_o, rd_lo_n_o, rd_hi_n_o} = 5'h1f;
    addr_o = 16'h0;
    data_o = 16'h0;
  end
  // ************
  // glue
  // ************
  assign ack_n_o = sel_n_o ? 1'bz : ~hold_n_i;
  task automatic access(input logic we, input logic [15:0] a, input logic [1:0] be,
    input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    int n;
    logic low;
    @(posedge bus_clk_i);
    sel_n_o <= 1'b0;
    addr_o <= a;
    if (we) begin
      data_o <= wd;
      wr_lo_n_o <= ~be[0];
      wr_hi_n_o <= ~be[1];
    end else begin
      rd_lo_n_o <= ~be[0];
      rd_hi_n_o <= ~be[1];
    end
    n = 0;
    do begin @(posedge bus_clk_i); n++; end while (hold_n_i !== 1'b0 && n < 8);
    low = (hold_n_i === 1'b0);
    do begin @(posedge bus_clk_i); n++; end while (hold_n_i !== 1'b1 && n < 400);
    rd = data_i;
    ok = low && n < 400;
    {sel_n_o, wr_lo_n_o, wr_hi_n_o, rd_lo_n_o, rd_hi_n_o} <= 5'h1f;
    data_o <= ~data_o;
  endtask
  task automatic stray(input logic sel_n, output logic quiet);
    @(posedge bus_clk_i);
    sel_n_o <= sel_n;
    {wr_lo_n_o, wr_hi_n_o} <= 2'h0;
    data_o <= 16'hffff;
    quiet = 1'b1;
    repeat (10) begin
      @(posedge bus_clk_i);
      if (hold_n_i !== 1'b1) quiet = 1'b0;
    end
    {sel_n_o, wr_lo_n_o, wr_hi_n_o} <= 3'h7;
  endtask
endmodule
`default_nettype wire

// >>> verif/lhbi_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lhbi_top_tb;
  logic clk_i, rst_i, bclk, bs_n, rfsh, rd, wr, sel_n, wlo, whi, rlo, rhi, oe, hold_n, pwr;
  logic wreq, ok;
  logic [3:0] ben;
  logic [4:0] strap;
  logic [3:0] adr;
  logic [31:0] wd, rdat, rv;
  logic [15:0] haddr, hdat, dout, hv;
  logic [5:0] cf [4] = '{6'h1f, 6'h03, 6'h27, 6'h07};
  wire [15:0] bus;
  wire ack_n;
  int n_mismatch, total_checks, cyc;
  assign bus = oe ? dout : hdat;
  lhbi_top dut (.clk_i(clk_i), .rst_i(rst_i), .host_bus_clk_i(bclk), .strap_cfg_i(strap),
    .bus_status_strap_n_i(bs_n), .device_sel_n_i(sel_n), .host_addr_in_i(haddr),
    .host_data_io_i(bus), .host_data_io_o(dout), .host_data_io_oe_o(oe),
    .low_byte_wr_n_i(wlo), .high_byte_wr_n_i(whi), .low_byte_rd_n_i(rlo),
    .high_byte_rd_n_i(rhi), .hold_n_o(hold_n), .panel_power_ctl_o(pwr), .refresh_req_i(rfsh),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(ben), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
  lhbi_host_model u_host (.bus_clk_i(bclk), .hold_n_i(hold_n), .data_i(bus), .sel_n_o(sel_n),
    .addr_o(haddr), .data_o(hdat), .wr_lo_n_o(wlo), .wr_hi_n_o(whi), .rd_lo_n_o(rlo),
    .rd_hi_n_o(rhi), .ack_n_o(ack_n));
  // ************
  // clocks
  // ************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    bclk = 1'b0;
    #3.3;
    forever #16 bclk = ~bclk;
  end
  // ************
  // tasks
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic we, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr <= we;
    rd <= ~we;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(32'(wreq), 32'h0);
  endtask
  task automatic do_reset(input logic [5:0] c);
    @(posedge clk_i);
    rst_i <= 1'b1;
    strap <= c[4:0];
    bs_n <= c[5];
    repeat (32) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge bclk);
  endtask
  task automatic hacc(input logic we, input logic [1:0] be, input logic [15:0] d);
    u_host.access(we, 16'h000a, be, d, hv, ok);
    chk(32'(ok), 32'h1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  // ************
  // sequence
  // ************
  initial begin
    {rst_i, bs_n, rfsh, rd, wr} = 5'h10;
    strap = 5'h07;
    adr = 4'h0;
    wd = 32'h0;
    ben = 4'hf;
    for (int i = 0; i < 4; i++) begin
      do_reset(cf[i]);
      chk(32'(pwr), {31'h0, ~cf[i][4]});
      av(1'b0, 4'h4, 32'h0, rv);
      chk(rv, {24'h0, 1'b0, (cf[i] & 6'h27) == 6'h07, cf[i]});
      if ((cf[i] & 6'h27) == 6'h07) begin
        if (i == 3) begin
          hacc(1'b0, 2'h3, 16'h0);
          chk(32'(hv), 32'hcd56);
        end
        hacc(1'b1, 2'h3, 16'h5678);
        hacc(1'b1, 2'h1, 16'h00cd);
        hacc(1'b0, 2'h3, 16'h0);
        chk(32'(hv), 32'h56cd);
        hacc(1'b0, 2'h2, 16'h0);
        chk(32'(hv[15:8]), 32'h56);
      end else begin
        u_host.stray(1'b0, ok);
        chk(32'(ok), 32'h1);
      end
    end
    u_host.stray(1'b1, ok);
    chk(32'(ok), 32'h1);
    hacc(1'b0, 2'h3, 16'h0);
    chk(32'(hv), 32'h56cd);
    av(1'b0, 4'h4, 32'h0, rv);
    chk(rv, 32'h0647);
    av(1'b1, 4'h0, 32'h1, rv);
    av(1'b0, 4'h0, 32'h0, rv);
    chk(rv, 32'h1);
    chk(32'(pwr), 32'h0);
    ben <= 4'he;
    av(1'b1, 4'h0, 32'h0, rv);
    ben <= 4'hf;
    av(1'b0, 4'h0, 32'h0, rv);
    chk(rv, 32'h1);
    av(1'b1, 4'h8, 32'hffff, rv);
    av(1'b0, 4'h8, 32'h0, rv);
    chk(rv, 32'h0);
    rfsh <= 1'b1;
    av(1'b1, 4'h0, 32'h3, rv);
    fork
      hacc(1'b0, 2'h3, 16'h0);
      begin
        repeat (30) @(posedge bclk);
        #1;
        chk(32'(hold_n), 32'h0);
        av(1'b0, 4'h4, 32'h0, rv);
        chk(32'(rv[7]), 32'h1);
        av(1'b1, 4'h0, 32'h1, rv);
        repeat (10) @(posedge bclk);
        #1;
        chk(32'(hold_n), 32'h0);
        @(posedge clk_i);
        rfsh <= 1'b0;
      end
    join
    chk(32'(hv), 32'h56cd);
    results();
  end
endmodule
`default_nettype wire
